/* File: src/nand_multi_io_buffer_read.sv */
// Multi-lane fast read path from the page data buffer to the serial link
// Behaviour
// - 3Ch: dual output, 4-byte address framing
// - 6Bh: quad output on four lanes
// - 6Ch: quad output, 4-byte address framing
// - BBh: address and dummy, data on two lanes
// - BCh: dual I/O, 4-byte address framing
// - EBh: address and data on four lanes
// - Write-protect enable ignores all quad reads
// - Buffer mode starts at column, runs sequentially
// - Buffer mode: lanes go hi-Z after last byte
// - Continuous mode starts at buffer byte zero
// - Continuous mode continues into next page
// - Continuous mode keeps streaming page after page
// - Bytes out on falling edge, MSB first
// - Read address increments after every byte, wrapping to zero after the last buffer byte in continuous mode
`timescale 1ns/1ps
`default_nettype none

module nand_multi_io_buffer_read
	import flash_read_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              wp_enable_i,
	input  wire logic              buf_mode_i,
	input  wire logic [PAGE_W-1:0] cur_page_i,
	output logic                   buf_rd_o,
	output logic      [COL_W-1:0]  buf_addr_o,
	input  wire logic [DATA_W-1:0] buf_data_i,
	output logic                   page_load_o,
	output logic      [PAGE_W-1:0] page_addr_o,
	input  wire logic              page_ready_i,
	input  wire logic              sclk_i,
	input  wire logic              cs_n_i,
	input  wire logic [3:0]        serial_lane_i,
	output logic      [3:0]        serial_lane_o,
	output logic      [3:0]        serial_lane_oe_o
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain registers
	logic              wp_s1_q;
	logic              wp_s2_q;
	logic              bm_s1_q;
	logic              bm_s2_q;
	link_phase_e       phase_q;
	logic [5:0]        cnt_q;
	logic [6:0]        opc_q;
	read_cmd_s         cmd_q;
	logic              cont_q;
	logic [15:0]       col_q;
	start_info_s       info_q;
	logic              start_tgl_q;
	logic [7:0]        sr_q;
	logic [1:0]        slot_q;
	logic [15:0]       baddr_q;
	logic              end_q;

	// Core domain registers
	logic              cs_s1_q;
	logic              cs_s2_q;
	logic              st_s1_q;
	logic              st_s2_q;
	logic              st_s3_q;
	fetch_state_e      state_q;
	logic [15:0]       addr_q;
	logic [15:0]       page_q;
	logic              cont_core_q;
	logic              pend_q;
	logic              page_load_q;

	// FIFO handshake
	logic              fifo_wr_ready;
	logic              fifo_rd_valid;
	logic [7:0]        fifo_rd_data;

	////////////////////////////////////////////////////////////////////////////
	// Opcode decode
	wire  [7:0]        opc_word = {opc_q, serial_lane_i[0]};
	read_cmd_s         dec_cmd;

	always_comb begin
		dec_cmd = '0;
		case (opc_word)
			OPC_DUAL_OUT_4B: dec_cmd = '{1'b1, LANES_1, LANES_2, 1'b1};
			OPC_QUAD_OUT:    dec_cmd = '{1'b1, LANES_1, LANES_4, 1'b0};
			OPC_QUAD_OUT_4B: dec_cmd = '{1'b1, LANES_1, LANES_4, 1'b1};
			OPC_DUAL_IO:     dec_cmd = '{1'b1, LANES_2, LANES_2, 1'b0};
			OPC_DUAL_IO_4B:  dec_cmd = '{1'b1, LANES_2, LANES_2, 1'b1};
			OPC_QUAD_IO:     dec_cmd = '{1'b1, LANES_4, LANES_4, 1'b0};
			default:         dec_cmd = '0;
		endcase
	end

	wire               dec_quad   = (dec_cmd.lanes_out == LANES_4);
	wire               dec_accept = dec_cmd.valid && !(dec_quad && wp_s2_q);

	////////////////////////////////////////////////////////////////////////////
	// Address and dummy phase
	wire  [5:0]        dummy_bits = cmd_q.addr4 ? (cont_q ? DUMMY_4B_CONT : DUMMY_4B_BUF)
	                                            : (cont_q ? DUMMY_BASE_CONT : DUMMY_BASE_BUF);
	wire  [5:0]        total_bits = COL_BITS + dummy_bits;
	wire  [5:0]        cnt_next   = cnt_q + {3'b000, cmd_q.lanes_in};
	wire               in_col     = (cnt_q < COL_BITS);
	wire               col_done   = in_col && (cnt_next == COL_BITS);
	wire               enter_data = (phase_q == P_ADDR) && (cnt_next == total_bits);
	wire  [15:0]       col_next   = (cmd_q.lanes_in == LANES_4) ? {col_q[11:0], serial_lane_i} :
	                                (cmd_q.lanes_in == LANES_2) ? {col_q[13:0], serial_lane_i[1:0]} :
	                                                              {col_q[14:0], serial_lane_i[0]};

	////////////////////////////////////////////////////////////////////////////
	// Data phase byte selection
	wire               is_quad    = (cmd_q.lanes_out == LANES_4);
	wire  [1:0]        slot_last  = is_quad ? SLOT_LAST_QUAD : SLOT_LAST_DUAL;
	wire               need_byte  = enter_data || ((phase_q == P_DATA) && !end_q && (slot_q == slot_last));
	wire  [15:0]       baddr_src  = enter_data ? info_q.col : baddr_q;
	wire               past_end   = !cont_q && (baddr_src >= BUF_BYTES);
	wire               wrap_addr  = cont_q && (baddr_src == BUF_LAST);
	wire  [15:0]       baddr_inc  = wrap_addr ? COL_FIRST : baddr_src + 16'h0001;
	wire               take_byte  = need_byte && !past_end;
	wire               fifo_pop   = take_byte && fifo_rd_valid;
	wire  [7:0]        new_byte   = fifo_rd_valid ? fifo_rd_data : UNDERRUN_BYTE;
	wire  [7:0]        sr_shift   = is_quad ? {sr_q[3:0], 4'h0} : {sr_q[5:0], 2'b00};

	////////////////////////////////////////////////////////////////////////////
	// Link domain: sampled on the rising serial clock, cleared by chip select
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			wp_s1_q <= 1'b0;
			wp_s2_q <= 1'b0;
			bm_s1_q <= 1'b0;
			bm_s2_q <= 1'b0;
		end else begin
			wp_s1_q <= wp_enable_i;
			wp_s2_q <= wp_s1_q;
			bm_s1_q <= buf_mode_i;
			bm_s2_q <= bm_s1_q;
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			phase_q <= P_OPC;
			cnt_q   <= CNT_RESET;
			opc_q   <= '0;
			cmd_q   <= '0;
			cont_q  <= 1'b0;
			col_q   <= '0;
		end else begin
			case (phase_q)
				P_OPC: begin
					opc_q <= opc_word[6:0];
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == OPC_LAST_BIT) begin
						cnt_q   <= CNT_RESET;
						cmd_q   <= dec_cmd;
						cont_q  <= !bm_s2_q;
						phase_q <= dec_accept ? P_ADDR : P_IGNORE;
					end
				end
				P_ADDR: begin
					cnt_q <= cnt_next;
					if (in_col) begin
						col_q <= col_next;
					end
					if (enter_data) begin
						phase_q <= P_DATA;
					end
				end
				P_DATA:   phase_q <= P_DATA;
				P_IGNORE: phase_q <= P_IGNORE;
				default:  phase_q <= P_IGNORE;
			endcase
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			info_q      <= '0;
			start_tgl_q <= 1'b0;
		end else if ((phase_q == P_ADDR) && col_done) begin
			info_q.cont <= cont_q;
			info_q.col  <= cont_q ? COL_FIRST : col_next;
			start_tgl_q <= !start_tgl_q;
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sr_q    <= '0;
			slot_q  <= '0;
			baddr_q <= '0;
			end_q   <= 1'b0;
		end else if (need_byte) begin
			end_q   <= past_end;
			sr_q    <= take_byte ? new_byte : sr_q;
			slot_q  <= '0;
			baddr_q <= take_byte ? baddr_inc : baddr_q;
		end else if (phase_q == P_DATA) begin
			sr_q    <= sr_shift;
			slot_q  <= slot_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lane drivers: change on the falling serial clock
	wire               drive     = (phase_q == P_DATA) && !end_q;
	wire  [3:0]        lane_bits = is_quad ? sr_q[7:4] : {2'b00, sr_q[7:6]};
	wire  [3:0]        lane_use  = is_quad ? 4'hF : 4'h3;

	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_lane
			always_ff @(negedge sclk_i or posedge cs_n_i) begin
				if (cs_n_i) begin
					serial_lane_o[gl]    <= 1'b0;
					serial_lane_oe_o[gl] <= 1'b0;
				end else begin
					serial_lane_o[gl]    <= lane_bits[gl];
					serial_lane_oe_o[gl] <= drive && lane_use[gl];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Core domain: frame tracking and start event
	wire               frame_rst = reset_i || cs_s2_q;
	wire               start_ev  = st_s2_q ^ st_s3_q;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n_i;
			cs_s2_q <= cs_s1_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (frame_rst) begin
			st_s1_q <= 1'b0;
			st_s2_q <= 1'b0;
			st_s3_q <= 1'b0;
		end else begin
			st_s1_q <= start_tgl_q;
			st_s2_q <= st_s1_q;
			st_s3_q <= st_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Core domain: fetch from the page data buffer into the FIFO
	wire               issue     = (state_q == F_FETCH) && (!pend_q || fifo_wr_ready);
	wire               at_last   = (addr_q == BUF_LAST);
	wire               start_bad = !info_q.cont && (info_q.col >= BUF_BYTES);

	assign buf_rd_o    = issue;
	assign buf_addr_o  = addr_q;
	assign page_load_o = page_load_q;
	assign page_addr_o = page_q;

	always_ff @(posedge clk_i) begin
		if (frame_rst) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= issue || (pend_q && !fifo_wr_ready);
		end
	end

	always_ff @(posedge clk_i) begin
		if (frame_rst) begin
			state_q     <= F_IDLE;
			addr_q      <= '0;
			page_q      <= '0;
			cont_core_q <= 1'b0;
			page_load_q <= 1'b0;
		end else begin
			page_load_q <= 1'b0;
			case (state_q)
				F_IDLE: begin
					if (start_ev) begin
						addr_q      <= info_q.col;
						page_q      <= cur_page_i;
						cont_core_q <= info_q.cont;
						state_q     <= start_bad ? F_DONE : F_FETCH;
					end
				end
				F_FETCH: begin
					if (issue && at_last && cont_core_q) begin
						page_q      <= page_q + 16'h0001;
						page_load_q <= 1'b1;
						state_q     <= F_PAGE;
					end else if (issue && at_last) begin
						state_q <= F_DONE;
					end else if (issue) begin
						addr_q <= addr_q + 16'h0001;
					end
				end
				F_PAGE: begin
					if (page_ready_i) begin
						addr_q  <= COL_FIRST;
						state_q <= F_FETCH;
					end
				end
				F_DONE:  state_q <= F_DONE;
				default: state_q <= F_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte FIFO between the core and the link
	cdc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.wr_clk_i   (clk_i),
		.wr_reset_i (frame_rst),
		.wr_valid_i (pend_q),
		.wr_ready_o (fifo_wr_ready),
		.wr_data_i  (buf_data_i),
		.rd_clk_i   (sclk_i),
		.rd_reset_i (cs_n_i),
		.rd_valid_o (fifo_rd_valid),
		.rd_ready_i (fifo_pop),
		.rd_data_o  (fifo_rd_data)
	);

endmodule : nand_multi_io_buffer_read

`default_nettype wire

/* File: inc/flash_read_pkg.sv */
// Constants, types and opcodes shared by the multi-lane buffer read path
package flash_read_pkg;

	localparam logic [7:0]  OPC_DUAL_OUT_4B = 8'h3C;
	localparam logic [7:0]  OPC_QUAD_OUT    = 8'h6B;
	localparam logic [7:0]  OPC_QUAD_OUT_4B = 8'h6C;
	localparam logic [7:0]  OPC_DUAL_IO     = 8'hBB;
	localparam logic [7:0]  OPC_DUAL_IO_4B  = 8'hBC;
	localparam logic [7:0]  OPC_QUAD_IO     = 8'hEB;

	localparam int          DATA_W          = 8;
	localparam int          FIFO_DEPTH      = 8;
	localparam int          COL_W           = 16;
	localparam int          PAGE_W          = 16;

	localparam logic [15:0] BUF_BYTES       = 16'h0840;
	localparam logic [15:0] BUF_LAST        = 16'h083F;
	localparam logic [15:0] COL_FIRST       = 16'h0000;

	localparam logic [5:0]  COL_BITS        = 6'h10;
	localparam logic [5:0]  DUMMY_BASE_BUF  = 6'h08;
	localparam logic [5:0]  DUMMY_BASE_CONT = 6'h20;
	localparam logic [5:0]  DUMMY_4B_BUF    = 6'h18;
	localparam logic [5:0]  DUMMY_4B_CONT   = 6'h28;
	localparam logic [5:0]  OPC_LAST_BIT    = 6'h07;
	localparam logic [5:0]  CNT_RESET       = 6'h00;

	localparam logic [2:0]  LANES_1         = 3'h1;
	localparam logic [2:0]  LANES_2         = 3'h2;
	localparam logic [2:0]  LANES_4         = 3'h4;
	localparam logic [1:0]  SLOT_LAST_QUAD  = 2'h1;
	localparam logic [1:0]  SLOT_LAST_DUAL  = 2'h3;

	localparam logic [7:0]  UNDERRUN_BYTE   = 8'hFF;

	typedef enum logic [1:0] {
		P_OPC    = 2'b00,
		P_ADDR   = 2'b01,
		P_DATA   = 2'b10,
		P_IGNORE = 2'b11
	} link_phase_e;

	typedef enum logic [1:0] {
		F_IDLE  = 2'b00,
		F_FETCH = 2'b01,
		F_PAGE  = 2'b10,
		F_DONE  = 2'b11
	} fetch_state_e;

	typedef struct packed {
		logic       valid;
		logic [2:0] lanes_in;
		logic [2:0] lanes_out;
		logic       addr4;
	} read_cmd_s;

	typedef struct packed {
		logic        cont;
		logic [15:0] col;
	} start_info_s;

endpackage : flash_read_pkg

/* File: src/cdc_fifo.sv */
// Dual-clock FIFO with gray-coded pointers between the core and the link clock
`timescale 1ns/1ps
`default_nettype none

module cdc_fifo
	import flash_read_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             wr_clk_i,
	input  wire logic             wr_reset_i,
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             rd_clk_i,
	input  wire logic             rd_reset_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic      [WIDTH-1:0] rd_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wbin_q;
	logic [AW:0]      wgray_q;
	logic [AW:0]      rbin_q;
	logic [AW:0]      rgray_q;
	logic [AW:0]      rg_s1_q;
	logic [AW:0]      rg_s2_q;
	logic [AW:0]      wg_s1_q;
	logic [AW:0]      wg_s2_q;
	logic [AW:0]      wbin_d;
	logic [AW:0]      rbin_d;
	wire              push;
	wire              pop;

	////////////////////////////////////////////////////////////////////////////
	// Write side
	assign wr_ready_o = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
	assign push       = wr_valid_i && wr_ready_o;
	assign wbin_d     = wbin_q + {{AW{1'b0}}, push};

	always_ff @(posedge wr_clk_i) begin
		if (push) begin
			mem_q[wbin_q[AW-1:0]] <= wr_data_i;
		end
	end

	always_ff @(posedge wr_clk_i) begin
		if (wr_reset_i) begin
			wbin_q  <= '0;
			wgray_q <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end else begin
			wbin_q  <= wbin_d;
			wgray_q <= wbin_d ^ (wbin_d >> 1);
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read side
	assign rd_valid_o = (rgray_q != wg_s2_q);
	assign rd_data_o  = mem_q[rbin_q[AW-1:0]];
	assign pop        = rd_valid_o && rd_ready_i;
	assign rbin_d     = rbin_q + {{AW{1'b0}}, pop};

	always_ff @(posedge rd_clk_i or posedge rd_reset_i) begin
		if (rd_reset_i) begin
			rbin_q  <= '0;
			rgray_q <= '0;
			wg_s1_q <= '0;
		end else begin
			rbin_q  <= rbin_d;
			rgray_q <= rbin_d ^ (rbin_d >> 1);
			wg_s1_q <= wgray_q;
		end
	end

	// Second stage on the falling edge: a word written while the link clock
	// was stopped is visible half a link period after the first rising edge, short dummy phases
	always_ff @(negedge rd_clk_i or posedge rd_reset_i) begin
		if (rd_reset_i) begin
			wg_s2_q <= '0;
		end else begin
			wg_s2_q <= wg_s1_q;
		end
	end

endmodule : cdc_fifo

`default_nettype wire

/* File: verif/nand_multi_io_buffer_read_chk.sv */
// Concurrent checks on the core-side ports and lane enables of the multi-lane read path
`timescale 1ns/1ps
`default_nettype none

module nand_multi_io_buffer_read_chk
	import flash_read_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        buf_mode_i,
	input wire logic        cs_n_i,
	input wire logic        buf_rd_o,
	input wire logic [15:0] buf_addr_o,
	input wire logic        page_load_o,
	input wire logic [15:0] page_addr_o,
	input wire logic        page_ready_i,
	input wire logic [3:0]  serial_lane_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Set by a page load request, cleared once the new page is reported ready
	logic load_wait_q;

	always_ff @(posedge clk_i) begin
		if (reset_i || cs_n_i) begin
			load_wait_q <= 1'b0;
		end else if (page_load_o) begin
			load_wait_q <= 1'b1;
		end else if (page_ready_i) begin
			load_wait_q <= 1'b0;
		end
	end

	a_oe_cs_idle: assert property (cs_n_i |-> serial_lane_oe_o == 4'h0)
		else $error("lanes driven while deselected");
	a_oe_lane_set: assert property (serial_lane_oe_o inside {4'h0, 4'h3, 4'hF})
		else $error("lane enable pattern illegal");
	a_reset_quiet: assert property ($fell(reset_i) |-> !buf_rd_o && !page_load_o && buf_addr_o == 16'h0000)
		else $error("core outputs active out of reset");
	a_rd_addr_step: assert property (buf_rd_o && !cs_n_i && buf_addr_o != BUF_LAST |=>
		buf_addr_o == $past(buf_addr_o) + 16'h0001)
		else $error("read address did not step by one");
	a_wrap_page_load: assert property (buf_rd_o && !cs_n_i && !buf_mode_i && buf_addr_o == BUF_LAST |=>
		page_load_o)
		else $error("no page load after last buffer byte");
	a_buf_end_stop: assert property (buf_rd_o && buf_mode_i && buf_addr_o == BUF_LAST |=> !buf_rd_o [*4])
		else $error("fetch continued past buffer end");
	a_load_one_pulse: assert property (page_load_o |=> !page_load_o)
		else $error("page load longer than one cycle");
	a_load_wait_ready: assert property (load_wait_q |-> !buf_rd_o)
		else $error("fetch before page was ready");
endmodule : nand_multi_io_buffer_read_chk

bind nand_multi_io_buffer_read nand_multi_io_buffer_read_chk chk (
	.clk_i           (clk_i),
	.reset_i         (reset_i),
	.buf_mode_i      (buf_mode_i),
	.cs_n_i          (cs_n_i),
	.buf_rd_o        (buf_rd_o),
	.buf_addr_o      (buf_addr_o),
	.page_load_o     (page_load_o),
	.page_addr_o     (page_addr_o),
	.page_ready_i    (page_ready_i),
	.serial_lane_oe_o(serial_lane_oe_o)
);

`default_nettype wire

/* File: verif/spi_host_model.sv */
// Host controller model driving chip select, serial clock and lanes
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	output logic            sclk_o,
	output logic            cs_n_o,
	output logic [3:0]      lane_o,
	input  wire logic [3:0] lane_i,
	input  wire logic [3:0] oe_i
);
	logic [7:0] rx_q[$];
	logic [3:0] oe_q[$];
	logic       bad_oe;

	// Chip select rises after time zero so the link reset edge is never missed
	initial begin
		sclk_o = 1'b0;
		lane_o = 4'h0;
		bad_oe = 1'b0;
		#1 cs_n_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic [7:0] opc, input logic [2:0] lin, input logic [2:0] lout,
		input logic [15:0] col, input int nd, input int nb);
		logic [63:0] sh;
		logic [7:0]  b;
		rx_q.delete();
		oe_q.delete();
		bad_oe = 1'b0;
		sh = {col, 48'h5A5A_C3C3_A5A5};
		cs_n_o = 1'b0;
		#2.3;
		for (int i = 7; i >= 0; i--) begin
			lane_o = {~lane_o[3:1], opc[i]};
			#3 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
		end
		for (int i = 0; i < 16 + nd; i += lin) begin
			lane_o = sh[63 -: 4] >> (4 - lin);
			sh = sh << lin;
			if (oe_i !== 4'h0) bad_oe = 1'b1;
			#3 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
			if (i + lin == 16) #100;
		end
		for (int k = 0; k < nb; k++) begin
			b = 8'h00;
			for (int j = 0; j < 8; j += lout) begin
				#3;
				if (j == 0) oe_q.push_back(oe_i);
				b = (b << lout) | {4'h0, lane_i & ((4'h1 << lout) - 4'h1)};
				lane_o = ~lane_o;
				sclk_o = 1'b1;
				#3 sclk_o = 1'b0;
			end
			rx_q.push_back(b);
		end
		#2 cs_n_o = 1'b1;
	endtask : xfer
endmodule : spi_host_model

`default_nettype wire

/* File: verif/nand_multi_io_buffer_read_test.sv */
// Self-checking bench for the multi-lane buffer read path
`timescale 1ns/1ps
`default_nettype none

module nand_multi_io_buffer_read_test;
	import flash_read_pkg::*;
	logic        clk_i, reset_i, wp_enable_i, buf_mode_i, page_ready_i, buf_rd_o, page_load_o;
	logic        sclk, cs_n, rd_s, ld_s;
	logic [15:0] cur_page_i, buf_addr_o, page_addr_o, pg_q, ad_s, pa_s;
	logic [7:0]  buf_data_i;
	logic [3:0]  host_lane, lane_w, serial_lane_o, serial_lane_oe_o;
	int          error_cnt, compares, seed, cycles, ld_wait;
	localparam logic [7:0] OPC [7] = '{OPC_DUAL_OUT_4B, OPC_QUAD_OUT, OPC_QUAD_OUT_4B, OPC_DUAL_IO,
		OPC_DUAL_IO_4B, OPC_QUAD_IO, 8'h0B};
	localparam logic [2:0] LIN [7] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h1};
	localparam logic [2:0] LOUT [7] = '{3'h2, 3'h4, 3'h4, 3'h2, 3'h2, 3'h4, 3'h1};
	localparam bit ADR4 [7] = '{1, 0, 1, 0, 1, 0, 0};
	localparam bit QUAD [7] = '{0, 1, 1, 0, 0, 1, 0};

	assign lane_w = (serial_lane_oe_o & serial_lane_o) | (~serial_lane_oe_o & host_lane);

	nand_multi_io_buffer_read dut (.clk_i(clk_i), .reset_i(reset_i), .wp_enable_i(wp_enable_i),
		.buf_mode_i(buf_mode_i), .cur_page_i(cur_page_i), .buf_rd_o(buf_rd_o), .buf_addr_o(buf_addr_o),
		.buf_data_i(buf_data_i), .page_load_o(page_load_o), .page_addr_o(page_addr_o),
		.page_ready_i(page_ready_i), .sclk_i(sclk), .cs_n_i(cs_n), .serial_lane_i(lane_w),
		.serial_lane_o(serial_lane_o), .serial_lane_oe_o(serial_lane_oe_o));
	spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .lane_o(host_lane), .lane_i(lane_w),
		.oe_i(serial_lane_oe_o));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] ram_byte(input logic [15:0] pg, input logic [15:0] a);
		return (a[7:0] ^ a[15:8]) + pg[7:0] + 8'h35;
	endfunction : ram_byte

	task automatic test_done;
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic run(input int k, input logic [15:0] col, input logic cont, input logic wp, input int nb);
		logic        ok;
		logic [15:0] a;
		int          nd;
		nd = ADR4[k] ? (cont ? 40 : 24) : (cont ? 32 : 8);
		@(posedge clk_i);
		#1;
		buf_mode_i = ~cont;
		wp_enable_i = wp;
		cur_page_i = 16'($random(seed));
		pg_q = cur_page_i;
		repeat (4) @(posedge clk_i);
		host.xfer(OPC[k], LIN[k], LOUT[k], col, nd, nb);
		check({15'h0, host.bad_oe}, 16'h0000);
		for (int i = 0; i < nb; i++) begin
			ok = k < 6 && !(wp && QUAD[k]) && (cont || col + i <= BUF_LAST);
			a = cont ? 16'(i % 2112) : 16'(col + i);
			check({12'h0, host.oe_q[i]}, ok ? (LOUT[k] == LANES_4 ? 16'hF : 16'h3) : 16'h0);
			if (ok) check({8'h0, host.rx_q[i]}, {8'h0, ram_byte(16'(cur_page_i + i / 2112), a)});
		end
		repeat (6) @(posedge clk_i);
	endtask : run

	////////////////////////////////////////////////////////////////////////
	always @(negedge clk_i) begin
		rd_s = buf_rd_o;
		ad_s = buf_addr_o;
		ld_s = page_load_o;
		pa_s = page_addr_o;
	end

	always @(posedge clk_i) begin
		#1;
		cycles++;
		if (rd_s) buf_data_i = ram_byte(pg_q, ad_s);
		page_ready_i = (ld_wait == 1);
		if (ld_wait > 0) ld_wait--;
		if (ld_s) begin
			pg_q = pa_s;
			ld_wait = 3;
		end
		if (cycles > 20000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		seed = 93;
		error_cnt = 0;
		compares = 0;
		cycles = 0;
		ld_wait = 0;
		reset_i = 1'b1;
		wp_enable_i = 1'b0;
		buf_mode_i = 1'b1;
		cur_page_i = 16'h0000;
		buf_data_i = 8'h00;
		page_ready_i = 1'b0;
		pg_q = 16'h0000;
		repeat (16) @(posedge clk_i);
		#1 reset_i = 1'b0;
		for (int k = 0; k < 7; k++) run(k, 16'h0005, 1'b0, 1'b0, 6);
		for (int k = 0; k < 6; k++) run(k, 16'($random(seed)), 1'b1, 1'b0, 5);
		for (int k = 0; k < 6; k++) run(k, 16'h083D, 1'b0, 1'b1, 5);
		run(1, 16'h0900, 1'b0, 1'b0, 2);
		repeat (8) run($unsigned($random(seed)) % 6, 16'($random(seed)) & 16'h0FFF,
			1'($random(seed)), 1'($random(seed)), 4);
		run(5, 16'h0000, 1'b1, 1'b0, 2116);
		test_done();
	end
endmodule : nand_multi_io_buffer_read_test

`default_nettype wire
